/* rtl/fdsb_bank.sv */
// Fan and digital status bank with AXI4-Lite slave, two status copies and GPIO state.
// Assumes all event and GPIO inputs are synchronous to aclk.
// Behaviour
// - Bits 0..7 of the fan byte flag faults of fans 1..8.
// - Host and manager each own a separate copy of both status bytes; software reset clears both together.
// - Digital bit 3 sets when the fan full-speed input is asserted.
// - Digital bits 4 and 5 set on termination inputs one and two.
// - Digital bit 6 sets on a voltage code mismatch fault.
// - Digital bit 7 sets on chassis intrusion input.
// - Digital bits 2..0 are reserved, read-only, read as zero.
// - Status bytes reset to zero on power-on and software reset; no lock.
// - Host general I/O byte reads 1 per asserted I/O line, writable.
`timescale 1ns/1ps
module fdsb_bank (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [fdsb_pkg::fdsb_addr_w-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [fdsb_pkg::fdsb_addr_w-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] fan_fault,
   input wire logic fan_full_speed_input,
   input wire logic termination_input_one,
   input wire logic termination_input_two,
   input wire logic voltage_code_mismatch,
   input wire logic chassis_intrusion_input,
   input wire logic [7:0] gio_in,
   output logic [7:0] gio_out,
   output logic irq
);
   import fdsb_pkg::*;

   logic aw_held_r;
   logic [fdsb_addr_w-1:0] aw_addr_r;
   logic w_held_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic wr_go;
   logic [7:0] wr_idx;
   logic [7:0] rd_idx;
   logic wr_hit;
   logic rd_hit;
   logic [31:0] rd_word;
   logic [7:0] gio_r;
   logic swrst_r;
   logic [4:0] dig_event;
   logic [7:0] host_fan;
   logic [7:0] host_dig;
   logic [7:0] mgr_fan;
   logic [7:0] mgr_dig;
   logic [7:0] fan_prev_r;
   logic [4:0] dig_prev_r;
   logic [fdsb_irq_w-1:0] irq_event;
   logic [fdsb_irq_w-1:0] irq_w1c;
   logic irq_mask_we;
   logic [fdsb_irq_w-1:0] irq_status;
   logic [fdsb_irq_w-1:0] irq_mask;

   // Address and data are taken independently, in either order, and held until the response.
   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready = !w_held_r && !bvalid_r;
   assign wr_go = aw_held_r && w_held_r && !bvalid_r;
   assign wr_idx = aw_addr_r[fdsb_addr_w-1:2];
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_r <= 1'b1;
         aw_addr_r <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_r <= 1'b0;
         w_data_r <= '0;
         w_strb_r <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_r <= 1'b1;
         w_data_r <= s_axi_wdata;
         w_strb_r <= s_axi_wstrb;
      end else if (wr_go) begin
         w_held_r <= 1'b0;
      end
   end

   always_comb begin
      unique case (wr_idx)
         fdsb_idx_host_fan, fdsb_idx_host_dig, fdsb_idx_host_gio, fdsb_idx_mgr_fan,
         fdsb_idx_mgr_dig, fdsb_idx_irq_stat, fdsb_idx_irq_mask, fdsb_idx_ctrl: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= fdsb_resp_okay;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_hit ? fdsb_resp_okay : fdsb_resp_slverr;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // Only byte lane 0 carries register data; a write with lane 0 off stores nothing.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gio_r <= fdsb_gio_rst;
      end else if (wr_go && w_strb_r[0] && wr_idx == fdsb_idx_host_gio) begin
         gio_r <= w_data_r[7:0];
      end
   end
   assign gio_out = gio_r;

   // Software reset is a self-clearing pulse that returns the status copies to zero.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         swrst_r <= 1'b0;
      end else begin
         swrst_r <= wr_go && w_strb_r[0] && wr_idx == fdsb_idx_ctrl
                    && w_data_r[fdsb_ctrl_swrst_bit];
      end
   end

   assign dig_event = {chassis_intrusion_input, voltage_code_mismatch, termination_input_two,
                       termination_input_one, fan_full_speed_input};

   // Two instances keep the host and manager copies apart; writes reach them only through the software reset clear.
   fdsb_flag_copy u_host_copy (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(swrst_r),
      .fan_fault(fan_fault),
      .dig_event(dig_event),
      .fan_flags(host_fan),
      .dig_flags(host_dig)
   );

   fdsb_flag_copy u_mgr_copy (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(swrst_r),
      .fan_fault(fan_fault),
      .dig_event(dig_event),
      .fan_flags(mgr_fan),
      .dig_flags(mgr_dig)
   );

   // Interrupt events fire when a host flag newly rises.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fan_prev_r <= fdsb_status_rst;
         dig_prev_r <= '0;
      end else begin
         fan_prev_r <= host_fan;
         dig_prev_r <= host_dig[fdsb_bit_intrusion:fdsb_bit_full_speed];
      end
   end

   assign irq_event[fdsb_irq_fan] = |(host_fan & ~fan_prev_r);
   assign irq_event[fdsb_irq_dig] = |(host_dig[fdsb_bit_intrusion:fdsb_bit_full_speed]
                                      & ~dig_prev_r);
   assign irq_w1c = (wr_go && w_strb_r[0] && wr_idx == fdsb_idx_irq_stat)
                    ? w_data_r[fdsb_irq_w-1:0] : '0;
   assign irq_mask_we = wr_go && w_strb_r[0] && wr_idx == fdsb_idx_irq_mask;

   fdsb_irq #(.N(fdsb_irq_w)) u_irq (
      .aclk(aclk),
      .aresetn(aresetn),
      .event_in(irq_event),
      .w1c(irq_w1c),
      .mask_we(irq_mask_we),
      .mask_wdata(w_data_r[fdsb_irq_w-1:0]),
      .status(irq_status),
      .mask(irq_mask),
      .irq(irq)
   );

   // Read channel: one read at a time, data registered one cycle after the address.
   assign s_axi_arready = !rvalid_r;
   assign rd_idx = s_axi_araddr[fdsb_addr_w-1:2];
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   always_comb begin
      rd_word = '0;
      rd_hit = 1'b1;
      unique case (rd_idx)
         fdsb_idx_host_fan: rd_word[7:0] = host_fan;
         fdsb_idx_host_dig: rd_word[7:0] = host_dig;
         fdsb_idx_host_gio: rd_word[7:0] = gio_in;
         fdsb_idx_mgr_fan: rd_word[7:0] = mgr_fan;
         fdsb_idx_mgr_dig: rd_word[7:0] = mgr_dig;
         fdsb_idx_irq_stat: rd_word[fdsb_irq_w-1:0] = irq_status;
         fdsb_idx_irq_mask: rd_word[fdsb_irq_w-1:0] = irq_mask;
         fdsb_idx_ctrl: rd_word = '0;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= fdsb_resp_okay;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_word;
         rresp_r <= rd_hit ? fdsb_resp_okay : fdsb_resp_slverr;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   fan_flag_sticky_a: assert property (fan_fault[0] && !swrst_r
      |=> host_fan[0] && mgr_fan[0])
      else $error("fan flag not set after fault");
   copies_match_a: assert property (host_dig == mgr_dig && host_fan == mgr_fan)
      else $error("host and manager copies differ");
   full_speed_a: assert property (fan_full_speed_input && !swrst_r |=> host_dig[3])
      else $error("full speed flag not set");
   term_flags_a: assert property (termination_input_one && termination_input_two && !swrst_r
      |=> host_dig[5:4] == 2'h3)
      else $error("termination flags not set");
   vcode_flag_a: assert property (voltage_code_mismatch && !swrst_r |=> mgr_dig[6])
      else $error("voltage code flag not set");
   intrusion_flag_a: assert property (chassis_intrusion_input && !swrst_r
      |=> host_dig[7])
      else $error("intrusion flag not set");
   reserved_zero_a: assert property (host_dig[2:0] == 3'h0 && mgr_dig[2:0] == 3'h0)
      else $error("reserved digital bits not zero");
   swrst_clear_a: assert property (swrst_r |=> host_fan == 8'h00 && mgr_dig == 8'h00)
      else $error("software reset did not clear status");
   gio_write_a: assert property (wr_go && w_strb_r[0] && wr_idx == fdsb_idx_host_gio
      |=> gio_out == $past(w_data_r[7:0]))
      else $error("general io write not stored");
   ro_write_a: assert property (wr_go && wr_idx == fdsb_idx_host_fan && !swrst_r
      && fan_fault == 8'h00 |=> host_fan == $past(host_fan))
      else $error("write changed read-only status");

   // Write channel: each half is refused once taken, and the answer follows both halves.
   aw_take_a: assert property (s_axi_awvalid && s_axi_awready
      |=> !s_axi_awready)
      else $error("write address accepted twice");
   w_take_a: assert property (s_axi_wvalid && s_axi_wready
      |=> !s_axi_wready)
      else $error("write data accepted twice");
   wr_answer_a: assert property (wr_go
      |=> s_axi_bvalid)
      else $error("write response missing");
   wr_refuse_a: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   wr_release_a: assert property (s_axi_bvalid && s_axi_bready
      |=> !s_axi_bvalid)
      else $error("write response not released");
   wr_error_a: assert property (wr_go && !wr_hit
      |=> s_axi_bresp == fdsb_resp_slverr)
      else $error("unmapped write not refused");

   // Read channel: one read in flight, answered on the next edge.
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
      else $error("read response missing");
   rd_refuse_a: assert property (s_axi_rvalid
      |-> !s_axi_arready)
      else $error("read accepted while data pending");
   rd_release_a: assert property (s_axi_rvalid && s_axi_rready
      |=> !s_axi_rvalid)
      else $error("read data not released");
   rd_error_a: assert property (s_axi_arvalid && s_axi_arready && !rd_hit
      |=> s_axi_rresp == fdsb_resp_slverr && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");

   // Read data carries the value present at the edge that took the address.
   gio_read_a: assert property (s_axi_arvalid && s_axi_arready
      && rd_idx == fdsb_idx_host_gio |=> s_axi_rdata == {24'h0, $past(gio_in)})
      else $error("general io read wrong");
   mgr_fan_read_a: assert property (s_axi_arvalid && s_axi_arready
      && rd_idx == fdsb_idx_mgr_fan |=> s_axi_rdata == {24'h0, $past(mgr_fan)})
      else $error("manager fan copy read wrong");
   dig_read_a: assert property (s_axi_arvalid && s_axi_arready
      && rd_idx == fdsb_idx_host_dig |=> s_axi_rdata[2:0] == 3'h0)
      else $error("reserved digital bits read nonzero");

   // Flags only ever rise between software resets.
   fan_keep_a: assert property (!swrst_r
      |=> (host_fan & $past(host_fan)) == $past(host_fan))
      else $error("fan flag dropped without reset");
   dig_keep_a: assert property (!swrst_r
      |=> (mgr_dig & $past(mgr_dig)) == $past(mgr_dig))
      else $error("digital flag dropped without reset");
   swrst_pulse_a: assert property (wr_go && w_strb_r[0] && wr_idx == fdsb_idx_ctrl
      && w_data_r[fdsb_ctrl_swrst_bit] |=> swrst_r)
      else $error("software reset not started");
   swrst_once_a: assert property (swrst_r
      |=> !swrst_r)
      else $error("software reset longer than one cycle");
   swrst_rest_a: assert property (swrst_r
      |=> host_dig == 8'h00 && mgr_fan == 8'h00)
      else $error("software reset left status set");

   // A new event beats a clear written in the same cycle, so no event is lost.
   irq_set_wins_a: assert property (|irq_event
      |=> (irq_status & $past(irq_event)) == $past(irq_event))
      else $error("interrupt event lost");
   irq_clear_a: assert property (irq_w1c[fdsb_irq_fan] && !irq_event[fdsb_irq_fan]
      |=> !irq_status[fdsb_irq_fan])
      else $error("interrupt status not cleared");
   irq_mask_a: assert property (irq_mask_we
      |=> irq_mask == w_data_r[fdsb_irq_w-1:0])
      else $error("interrupt mask not stored");

   wr_done_c: cover property (wr_go ##1 s_axi_bvalid && s_axi_bready);
   rd_done_c: cover property (s_axi_arvalid && s_axi_arready ##1 s_axi_rvalid);
   irq_rise_c: cover property (!irq ##1 irq);
   swrst_c: cover property (swrst_r);
   irq_fall_c: cover property (irq ##1 !irq);
endmodule // fdsb_bank

/* include/fdsb_pkg.sv */
// Package for the fan and digital status bank: register map, bit positions, reset values.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package fdsb_pkg;
   localparam int unsigned fdsb_addr_w = 10;
   // Printed offsets are not multiples of four: each is an index, the byte address is 4x.
   localparam logic [7:0] fdsb_idx_host_fan = 8'hbd;
   localparam logic [7:0] fdsb_idx_host_dig = 8'hbe;
   localparam logic [7:0] fdsb_idx_host_gio = 8'hbf;
   localparam logic [7:0] fdsb_idx_mgr_fan = 8'hc5;
   localparam logic [7:0] fdsb_idx_mgr_dig = 8'hc6;
   localparam logic [7:0] fdsb_idx_irq_stat = 8'hd0;
   localparam logic [7:0] fdsb_idx_irq_mask = 8'hd1;
   localparam logic [7:0] fdsb_idx_ctrl = 8'hd2;
   localparam int unsigned fdsb_ctrl_swrst_bit = 0;
   localparam int unsigned fdsb_bit_full_speed = 3;
   localparam int unsigned fdsb_bit_term_one = 4;
   localparam int unsigned fdsb_bit_term_two = 5;
   localparam int unsigned fdsb_bit_vcode = 6;
   localparam int unsigned fdsb_bit_intrusion = 7;
   localparam logic [7:0] fdsb_status_rst = 8'h00;
   localparam logic [7:0] fdsb_gio_rst = 8'h00;
   localparam logic [1:0] fdsb_resp_okay = 2'h0;
   localparam logic [1:0] fdsb_resp_slverr = 2'h2;
   // Interrupt status layout: bit0 any fan flag rose, bit1 any digital flag rose.
   localparam int unsigned fdsb_irq_w = 2;
   localparam int unsigned fdsb_irq_fan = 0;
   localparam int unsigned fdsb_irq_dig = 1;
endpackage

/* rtl/fdsb_flag_copy.sv */
// One copy of the fan and digital status bytes, for either the host or the manager.
// Assumes event inputs are synchronous to aclk.
`timescale 1ns/1ps
module fdsb_flag_copy (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clear,
   input wire logic [7:0] fan_fault,
   input wire logic [4:0] dig_event,
   output logic [7:0] fan_flags,
   output logic [7:0] dig_flags
);
   import fdsb_pkg::*;
   logic [7:0] fan_r;
   logic [7:0] dig_r;
   logic [7:0] dig_set;

   // Reserved bits 2:0 stay zero because no event drives them.
   assign dig_set = {dig_event, 3'h0};

   // Flags are sticky so a brief input pulse is not missed; only reset or the clear input clears them.
   always_ff @(posedge aclk) begin
      if (!aresetn || clear) begin
         fan_r <= fdsb_status_rst;
         dig_r <= fdsb_status_rst;
      end else begin
         fan_r <= fan_r | fan_fault;
         dig_r <= dig_r | dig_set;
      end
   end

   assign fan_flags = fan_r;
   assign dig_flags = dig_r;
endmodule // fdsb_flag_copy

/* rtl/fdsb_irq.sv */
// Sticky interrupt status with write-one-to-clear, a mask, and one level output.
// Assumes events are one-cycle or level signals synchronous to aclk.
`timescale 1ns/1ps
module fdsb_irq #(
   parameter int unsigned N = 2
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [N-1:0] event_in,
   input wire logic [N-1:0] w1c,
   input wire logic mask_we,
   input wire logic [N-1:0] mask_wdata,
   output logic [N-1:0] status,
   output logic [N-1:0] mask,
   output logic irq
);
   logic [N-1:0] status_r;
   logic [N-1:0] mask_r;

   // A set in the same cycle as its clear wins, so no event is lost.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_r <= '0;
      end else begin
         status_r <= (status_r & ~w1c) | event_in;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_r <= '0;
      end else if (mask_we) begin
         mask_r <= mask_wdata;
      end
   end

   assign status = status_r;
   assign mask = mask_r;
   assign irq = |(status_r & mask_r);
endmodule // fdsb_irq

/* verif/fdsb_host_model.sv */
// Register bus master standing in for host or manager software on AXI4-Lite.
// Assumes the slave samples on the rising edge of aclk; the bench calls wr and rd after an edge.
`timescale 1ns/1ps
module fdsb_host_model (
   input wire logic aclk,
   output logic [fdsb_pkg::fdsb_addr_w-1:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [fdsb_pkg::fdsb_addr_w-1:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   import fdsb_pkg::*;
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   // Released payloads are inverted so that a slave sampling too late reads garbage.
   task automatic wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] resp);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) begin
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
            wdata <= ~d;
         end
         if (bvalid) begin
            resp = bresp;
            bready <= 1'b0;
            break;
         end
      end
      @(posedge aclk);
   endtask
   task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] resp);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) begin
            arvalid <= 1'b0;
            araddr <= ~a;
         end
         if (rvalid) begin
            d = rdata;
            resp = rresp;
            rready <= 1'b0;
            break;
         end
      end
      @(posedge aclk);
   endtask
endmodule // fdsb_host_model

/* verif/tb.sv */
// Self-checking bench for the fan and digital status bank.
// Assumes the bus master model drives the register bus; events are pulsed by the bench.
`timescale 1ns/1ps
module tb;
   import fdsb_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] fan_fault = 8'h00;
   logic [7:0] gio_in = 8'h00;
   logic [4:0] dig = 5'h00;
   logic [9:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0] gio_out;
   logic irq;
   int bad_count = 0;
   int comparisons = 0;
   logic [7:0] g, f, e, w;
   logic [7:0] st [4] = '{fdsb_idx_host_fan, fdsb_idx_host_dig,
                          fdsb_idx_mgr_fan, fdsb_idx_mgr_dig};
   always #10 aclk = ~aclk;
   fdsb_host_model u_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   fdsb_bank dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fan_fault(fan_fault),
      .fan_full_speed_input(dig[0]), .termination_input_one(dig[1]),
      .termination_input_two(dig[2]), .voltage_code_mismatch(dig[3]),
      .chassis_intrusion_input(dig[4]), .gio_in(gio_in), .gio_out(gio_out), .irq(irq));
   task automatic end_of_test();
      $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   // Read data is compared only when an OKAY answer is expected; an error answer carries no defined data.
   task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      u_host.rd({idx, 2'b00}, d, r);
      if (er === fdsb_resp_okay) chk(d, exp);
      chk({30'h0, r}, {30'h0, er});
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      u_host.wr({idx, 2'b00}, d, r);
      chk({30'h0, r}, {30'h0, er});
   endtask
   task automatic pulse(input logic [7:0] ff, input logic [4:0] dg);
      fan_fault <= ff;
      dig <= dg;
      @(posedge aclk);
      fan_fault <= 8'h00;
      dig <= 5'h00;
      @(posedge aclk);
   endtask
   function automatic logic [7:0] dig_bit(input int i);
      return 8'h01 << (fdsb_bit_full_speed + i);
   endfunction
   initial begin
      #400us;
      bad_count++;
      end_of_test();
   end
   initial begin
      void'($urandom(32'h57784116));
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      g = 8'($urandom);
      gio_in <= g;
      @(posedge aclk);
      foreach (st[k]) rd(st[k], 32'h0, fdsb_resp_okay);
      rd(fdsb_idx_host_gio, {24'h0, g}, fdsb_resp_okay);
      w = 8'($urandom);
      wr(fdsb_idx_host_gio, {24'h0, w}, fdsb_resp_okay);
      chk({24'h0, gio_out}, {24'h0, w});
      f = 8'($urandom);
      pulse(f, 5'h00);
      rd(fdsb_idx_host_fan, {24'h0, f}, fdsb_resp_okay);
      pulse(8'h81, 5'h00);
      f = f | 8'h81;
      rd(fdsb_idx_host_fan, {24'h0, f}, fdsb_resp_okay);
      rd(fdsb_idx_mgr_fan, {24'h0, f}, fdsb_resp_okay);
      e = 8'h00;
      for (int i = 0; i < 5; i++) begin
         pulse(8'h00, 5'h01 << i);
         e = e | dig_bit(i);
         rd(fdsb_idx_host_dig, {24'h0, e}, fdsb_resp_okay);
         rd(fdsb_idx_mgr_dig, {24'h0, e}, fdsb_resp_okay);
      end
      wr(fdsb_idx_host_fan, 32'h0, fdsb_resp_okay);
      rd(fdsb_idx_host_fan, {24'h0, f}, fdsb_resp_okay);
      wr(fdsb_idx_mgr_dig, 32'hff, fdsb_resp_okay);
      rd(fdsb_idx_mgr_dig, {24'h0, e}, fdsb_resp_okay);
      rd(8'h00, 32'h0, fdsb_resp_slverr);
      wr(8'h01, 32'h1, fdsb_resp_slverr);
      wr(fdsb_idx_ctrl, 32'h1, fdsb_resp_okay);
      repeat (3) @(posedge aclk);
      foreach (st[k]) rd(st[k], 32'h0, fdsb_resp_okay);
      wr(fdsb_idx_irq_stat, 32'h3, fdsb_resp_okay);
      wr(fdsb_idx_irq_mask, 32'h3, fdsb_resp_okay);
      chk({31'h0, irq}, 32'h0);
      pulse(8'h01, 5'h00);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h1);
      rd(fdsb_idx_irq_stat, 32'h1, fdsb_resp_okay);
      wr(fdsb_idx_irq_stat, 32'h1, fdsb_resp_okay);
      chk({31'h0, irq}, 32'h0);
      wr(fdsb_idx_irq_mask, 32'h1, fdsb_resp_okay);
      pulse(8'h00, 5'h10);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h0);
      rd(fdsb_idx_irq_stat, 32'h2, fdsb_resp_okay);
      // A reset in mid-run must clear every flag that the events have just set.
      pulse(8'($urandom), 5'h1f);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      foreach (st[k]) rd(st[k], 32'h0, fdsb_resp_okay);
      rd(fdsb_idx_irq_stat, 32'h0, fdsb_resp_okay);
      chk({31'h0, irq}, 32'h0);
      chk({24'h0, gio_out}, {24'h0, fdsb_gio_rst});
      end_of_test();
   end
endmodule // tb
